// ---- logic/psc_pkg.sv ----
// shared constants and types for the pressure sensor command block
package psc_pkg;
  // system clock period
  localparam int unsigned SYS_CLK_NS = 20;
  // conversion times per setting, in ns (typical)
  localparam int unsigned T_CON1_NS = 395000;
  localparam int unsigned T_CON2_NS = 790000;
  localparam int unsigned T_CON3_NS = 1580000;
  localparam int unsigned T_CON4_NS = 3160000;
  // extra time for the temperature pass and correction refresh
  localparam int unsigned T_TEMP_NS = 500000;
  // reset and boot load time
  localparam int unsigned T_BOOT_NS = 10000;
  localparam int unsigned CON1_CYC = T_CON1_NS / SYS_CLK_NS;
  localparam int unsigned CON2_CYC = T_CON2_NS / SYS_CLK_NS;
  localparam int unsigned CON3_CYC = T_CON3_NS / SYS_CLK_NS;
  localparam int unsigned CON4_CYC = T_CON4_NS / SYS_CLK_NS;
  localparam int unsigned TEMP_CYC = T_TEMP_NS / SYS_CLK_NS;
  localparam int unsigned BOOT_CYC = T_BOOT_NS / SYS_CLK_NS;
  // timer and data widths
  localparam int unsigned CNT_W = 20;
  localparam int unsigned DATA_W = 24;
  // temperature pass on this counter value, one every 256 conversions
  localparam logic [7:0] TEMP_EVERY_LAST = 8'hff;
  // command byte encodings
  localparam logic [7:0] CMD_RESET = 8'h72;
  localparam logic [7:0] CMD_IDLE = 8'h94;
  localparam logic [7:0] CMD_RESULT = 8'hc0;
  localparam logic [7:0] CMD_STATUS = 8'h80;
  localparam logic [5:0] CMD_ACTIVE_HI = 6'h28;
  localparam logic [5:0] CMD_FILTER_HI = 6'h2c;
  // answer codes on the first returned byte
  localparam logic [7:0] ANS_ACK = 8'ha5;
  localparam logic [7:0] ANS_NACK = 8'h5a;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] CUTOFF_RST = 2'h0;
  localparam logic [7:0] TEMP_CNT_RST = 8'hff;

  typedef enum logic [1:0] {
    PSC_MODE_FASTEST,
    PSC_MODE_SECOND,
    PSC_MODE_THIRD,
    PSC_MODE_SLOWEST
  } psc_mode_t;

  typedef enum logic [2:0] {
    PSC_C_NONE,
    PSC_C_RESET,
    PSC_C_ACTIVE,
    PSC_C_RESULT,
    PSC_C_IDLE,
    PSC_C_FILTER,
    PSC_C_STATUS
  } psc_cmd_t;

  typedef enum logic [1:0] {
    PSC_ST_SHUTDOWN,
    PSC_ST_BOOT,
    PSC_ST_IDLE,
    PSC_ST_ACTIVE
  } psc_state_t;
endpackage : psc_pkg

// ---- logic/psc_conv_timer.sv ----
// conversion timer: one done pulse per conversion, longer on temperature passes
`timescale 1ns/100ps
module psc_conv_timer
  import psc_pkg::*;
#(
  parameter logic [CNT_W-1:0] FASTEST_CONVERSION_SETTING_CYC = CON1_CYC[CNT_W-1:0],
  parameter logic [CNT_W-1:0] SECOND_CONVERSION_SETTING_CYC = CON2_CYC[CNT_W-1:0],
  parameter logic [CNT_W-1:0] THIRD_CONVERSION_SETTING_CYC = CON3_CYC[CNT_W-1:0],
  parameter logic [CNT_W-1:0] SLOWEST_CONVERSION_SETTING_CYC = CON4_CYC[CNT_W-1:0],
  parameter logic [CNT_W-1:0] EXTRA_CYC = TEMP_CYC[CNT_W-1:0]
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic i_stop,
  input wire psc_mode_t i_mode,
  input wire logic i_with_temp,
  // status
  output logic o_done,
  output logic o_busy
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] base_cyc;
  logic busy_q;
  logic busy_d;

  // nominal length per setting
  assign base_cyc = (i_mode == PSC_MODE_FASTEST) ? FASTEST_CONVERSION_SETTING_CYC :
                    (i_mode == PSC_MODE_SECOND) ? SECOND_CONVERSION_SETTING_CYC :
                    (i_mode == PSC_MODE_THIRD) ? THIRD_CONVERSION_SETTING_CYC : SLOWEST_CONVERSION_SETTING_CYC;
  assign o_done = busy_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  assign o_busy = busy_q;

  // start wins over a running count so a restart is exact
  assign busy_d = i_stop ? 1'b0 : (i_start ? 1'b1 : (o_done ? 1'b0 : busy_q));
  assign cnt_d = i_start ? (base_cyc + (i_with_temp ? EXTRA_CYC : '0)) :
                 (busy_q ? cnt_q - 1'b1 : cnt_q);

  // down counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end
endmodule : psc_conv_timer

// ---- logic/psc_cmd_fsm.sv ----
// command interpreter of the pressure sensor: serial command byte in, state machine, answers out
//
// Operation
// - deliver corrected pressure as 24-bit value
// - fastest setting converts in 0.395 ms
// - second setting converts in 0.790 ms
// - third setting converts in 1.58 ms
// - slowest setting converts in 3.16 ms
// - every 256th conversion adds temperature correction
// - reset command reboots then enters shutdown
// - activate starts conversion, booting first from shutdown
// - ignored commands answer NACK, keep state
// - result read while active returns latest value
// - result read while idle: ACK, no result
// - idle from shutdown boots; idle keeps idle
// - filter write in idle changes cutoff
// - completion output goes low when conversion done
`timescale 1ns/100ps
module psc_cmd_fsm
  import psc_pkg::*;
#(
  parameter int unsigned FASTEST_CONVERSION_SETTING_CYC = CON1_CYC,
  parameter int unsigned SECOND_CONVERSION_SETTING_CYC = CON2_CYC,
  parameter int unsigned THIRD_CONVERSION_SETTING_CYC = CON3_CYC,
  parameter int unsigned SLOWEST_CONVERSION_SETTING_CYC = CON4_CYC,
  parameter int unsigned EXTRA_CYC = TEMP_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial link pins from the host
  input wire logic i_link_clk,
  input wire logic i_link_cs_n,
  input wire logic i_link_mosi,
  output logic o_link_miso,
  // strap
  input wire logic i_proto_sel,
  // converter front end, same clock
  input wire logic [psc_pkg::DATA_W-1:0] i_bridge_sample,
  input wire logic [psc_pkg::DATA_W-1:0] i_temp_offset,
  // status
  output logic o_conversion_done_n,
  output logic o_cmd_ack,
  output logic o_cmd_nack
);
  import psc_pkg::*;

  // decode a received byte into a command class
  function automatic psc_cmd_t decode_cmd(input logic [7:0] b);
    psc_cmd_t c;
    c = PSC_C_NONE;
    if (b == CMD_RESET) c = PSC_C_RESET;
    else if (b == CMD_IDLE) c = PSC_C_IDLE;
    else if (b == CMD_RESULT) c = PSC_C_RESULT;
    else if (b == CMD_STATUS) c = PSC_C_STATUS;
    else if (b[7:2] == CMD_ACTIVE_HI) c = PSC_C_ACTIVE;
    else if (b[7:2] == CMD_FILTER_HI) c = PSC_C_FILTER;
    return c;
  endfunction : decode_cmd

  // synchronisers, two stages so edges are found on settled copies
  logic [1:0] clk_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] psel_sync_q;
  logic clk_last_q;
  logic rise;
  logic fall;
  logic cs_act;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clk_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      mosi_sync_q <= 2'h0;
      psel_sync_q <= 2'h0;
      clk_last_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], i_link_clk};
      cs_sync_q <= {cs_sync_q[0], i_link_cs_n};
      mosi_sync_q <= {mosi_sync_q[0], i_link_mosi};
      psel_sync_q <= {psel_sync_q[0], i_proto_sel};
      clk_last_q <= clk_sync_q[1];
    end
  end

  assign cs_act = !cs_sync_q[1];
  assign rise = cs_act && clk_sync_q[1] && !clk_last_q;
  assign fall = cs_act && !clk_sync_q[1] && clk_last_q;

  // command byte receiver: only the first byte of a frame is a command
  logic [7:0] rx_q;
  logic [3:0] bits_q;
  logic cmd_stb;
  logic [7:0] rx_byte;

  assign rx_byte = {rx_q[6:0], mosi_sync_q[1]};
  assign cmd_stb = rise && (bits_q == 4'h7);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !cs_act) begin
      rx_q <= 8'h00;
      bits_q <= 4'h0;
    end else if (rise && bits_q != 4'h8) begin
      rx_q <= rx_byte;
      bits_q <= bits_q + 4'h1;
    end
  end

  // state machine and settings
  psc_state_t state_q;
  psc_state_t state_d;
  psc_state_t target_q;
  psc_state_t target_d;
  psc_mode_t mode_q;
  psc_mode_t mode_d;
  logic [1:0] cutoff_q;
  logic [1:0] cutoff_d;
  logic [CNT_W-1:0] boot_q;
  logic [CNT_W-1:0] boot_d;
  psc_cmd_t cmd;
  logic ack;
  logic conv_start;
  logic conv_stop;
  logic conv_done;
  logic temp_pass;

  assign cmd = cmd_stb ? decode_cmd(rx_byte) : PSC_C_NONE;

  always_comb begin
    state_d = state_q;
    target_d = target_q;
    mode_d = mode_q;
    cutoff_d = cutoff_q;
    ack = 1'b0;
    boot_d = (state_q == PSC_ST_BOOT && boot_q != '0) ? boot_q - 1'b1 : boot_q;
    conv_start = 1'b0;
    unique case (cmd)
      PSC_C_RESET: begin
        state_d = PSC_ST_BOOT;
        target_d = PSC_ST_SHUTDOWN;
        // a reset command returns mode and cutoff to defaults; temperature counter, offset and result are kept
        mode_d = psc_mode_t'(MODE_RST);
        cutoff_d = CUTOFF_RST;
        boot_d = BOOT_CYC[CNT_W-1:0];
        ack = 1'b1;
      end
      PSC_C_ACTIVE: begin
        if (state_q == PSC_ST_SHUTDOWN) begin
          state_d = PSC_ST_BOOT;
          target_d = PSC_ST_ACTIVE;
          boot_d = BOOT_CYC[CNT_W-1:0];
          mode_d = psc_mode_t'(rx_byte[1:0]);
          ack = 1'b1;
        end else if (state_q == PSC_ST_IDLE) begin
          state_d = PSC_ST_ACTIVE;
          mode_d = psc_mode_t'(rx_byte[1:0]);
          conv_start = 1'b1;
          ack = 1'b1;
        end
      end
      PSC_C_RESULT: ack = (state_q == PSC_ST_ACTIVE) || (state_q == PSC_ST_IDLE);
      PSC_C_IDLE: begin
        if (state_q == PSC_ST_SHUTDOWN) begin
          state_d = PSC_ST_BOOT;
          target_d = PSC_ST_IDLE;
          boot_d = BOOT_CYC[CNT_W-1:0];
          ack = 1'b1;
        end else if (state_q != PSC_ST_BOOT) begin
          state_d = PSC_ST_IDLE;
          ack = 1'b1;
        end
      end
      PSC_C_FILTER: begin
        if (state_q == PSC_ST_IDLE || state_q == PSC_ST_ACTIVE) begin
          cutoff_d = rx_byte[1:0];
          ack = 1'b1;
        end
      end
      PSC_C_STATUS: ack = 1'b1;
      default: begin
        if (state_q == PSC_ST_BOOT && boot_q == '0) begin
          state_d = target_q;
          conv_start = (target_q == PSC_ST_ACTIVE);
        end
      end
    endcase
    if (conv_done && state_d == PSC_ST_ACTIVE && state_q == PSC_ST_ACTIVE) begin
      conv_start = 1'b1; // back-to-back conversions while active
    end
  end

  // boot is entered after power-on reset too
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= PSC_ST_BOOT;
      target_q <= PSC_ST_SHUTDOWN;
      boot_q <= BOOT_CYC[CNT_W-1:0];
      mode_q <= psc_mode_t'(MODE_RST);
      cutoff_q <= CUTOFF_RST;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      boot_q <= boot_d;
      mode_q <= mode_d;
      cutoff_q <= cutoff_d;
    end
  end

  // conversion timing
  assign conv_stop = (state_d != PSC_ST_ACTIVE);

  psc_conv_timer #(
    .FASTEST_CONVERSION_SETTING_CYC(FASTEST_CONVERSION_SETTING_CYC[CNT_W-1:0]),
    .SECOND_CONVERSION_SETTING_CYC(SECOND_CONVERSION_SETTING_CYC[CNT_W-1:0]),
    .THIRD_CONVERSION_SETTING_CYC(THIRD_CONVERSION_SETTING_CYC[CNT_W-1:0]),
    .SLOWEST_CONVERSION_SETTING_CYC(SLOWEST_CONVERSION_SETTING_CYC[CNT_W-1:0]),
    .EXTRA_CYC(EXTRA_CYC[CNT_W-1:0])
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_start(conv_start && !conv_stop),
    .i_stop(conv_stop),
    .i_mode(mode_d),
    .i_with_temp(temp_pass),
    .o_done(conv_done),
    .o_busy()
  );

  // temperature pass counter: wraps so one conversion in 256 is long
  logic [7:0] temp_cnt_q;
  logic [DATA_W-1:0] offset_q;
  logic [DATA_W-1:0] corr;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] filt_step;
  logic temp_now_q;

  assign temp_pass = (temp_cnt_q == TEMP_EVERY_LAST);
  assign corr = i_bridge_sample - offset_q;
  assign filt_step = DATA_W'($signed(corr - result_q) >>> cutoff_q);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      temp_cnt_q <= TEMP_CNT_RST;
      temp_now_q <= 1'b0;
      offset_q <= '0;
      result_q <= '0;
    end else begin
      if (conv_start && !conv_stop) begin
        temp_cnt_q <= temp_cnt_q + 8'h01;
        temp_now_q <= temp_pass;
      end
      if (conv_done && temp_now_q) begin
        offset_q <= i_temp_offset;
      end
      if (conv_done) begin
        result_q <= result_q + filt_step;
      end
    end
  end

  // completion output: low on done, high on read or leaving active
  logic done_n_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_n_q <= 1'b1;
    end else if (conv_done && state_q == PSC_ST_ACTIVE) begin
      done_n_q <= 1'b0;
    end else if (cmd == PSC_C_RESULT || state_q != PSC_ST_ACTIVE) begin
      done_n_q <= 1'b1;
    end
  end

  assign o_conversion_done_n = done_n_q;

  // answer: code byte then 24 data bits, loaded on the fall after the command
  logic [31:0] ans_q;
  logic [31:0] ans_pend_q;
  logic load_q;
  logic [DATA_W-1:0] payload;
  logic [7:0] status_code;

  assign status_code = {psel_sync_q[1], 1'b0, state_q, mode_q, cutoff_q};
  assign payload = (cmd == PSC_C_RESULT && state_q == PSC_ST_ACTIVE) ? result_q :
                   (cmd == PSC_C_STATUS) ? {16'h0000, status_code} : '0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !cs_act) begin
      ans_q <= '0;
      ans_pend_q <= '0;
      load_q <= 1'b0;
    end else if (cmd_stb) begin
      ans_pend_q <= {(ack ? ANS_ACK : ANS_NACK), payload};
      load_q <= 1'b1;
    end else if (fall) begin
      ans_q <= load_q ? ans_pend_q : {ans_q[30:0], 1'b0};
      load_q <= 1'b0;
    end
  end

  assign o_link_miso = ans_q[31];
  assign o_cmd_ack = cmd_stb && ack;
  assign o_cmd_nack = cmd_stb && !ack;
endmodule : psc_cmd_fsm

// ---- tb/psc_cmd_monitor.sv ----
// port checker for the command block
`timescale 1ns/100ps
module psc_cmd_monitor
  import psc_pkg::*;
#(
  parameter int unsigned FASTEST_CONVERSION_SETTING_CYC = CON1_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link
  input wire logic i_link_clk,
  input wire logic i_link_cs_n,
  input wire logic o_link_miso,
  // status
  input wire logic o_conversion_done_n,
  input wire logic o_cmd_ack,
  input wire logic o_cmd_nack
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic prev_q;
  logic [19:0] gap_q;
  wire fell_w = prev_q & ~o_conversion_done_n;
  // cycles since last completion edge, saturating so it never wraps
  always_ff @(posedge i_sys_clk) begin
    prev_q <= o_conversion_done_n;
    if (!i_rst_n || fell_w) gap_q <= 20'h0;
    else if (gap_q != 20'hfffff) gap_q <= gap_q + 20'h1;
  end
  ack_nack_excl_a: assert property (!(o_cmd_ack && o_cmd_nack))
    else $error("ack and nack together");
  ack_pulse_a: assert property (o_cmd_ack |=> !o_cmd_ack)
    else $error("ack wider than one cycle");
  nack_pulse_a: assert property (o_cmd_nack |=> !o_cmd_nack)
    else $error("nack wider than one cycle");
  boot_quiet_a: assert property ($rose(i_rst_n) |-> (o_conversion_done_n && !o_cmd_ack && !o_cmd_nack) [*8])
    else $error("activity right after reset");
  answer_framed_a: assert property ((o_cmd_ack || o_cmd_nack) |-> !$past(i_link_cs_n, 3))
    else $error("answer outside a frame");
  done_release_a: assert property ($rose(o_conversion_done_n) |-> $past(o_cmd_ack) || $past(o_cmd_ack, 2))
    else $error("completion released without a command");
  conv_min_gap_a: assert property (fell_w |-> gap_q >= FASTEST_CONVERSION_SETTING_CYC)
    else $error("conversion shorter than fastest setting");
  miso_on_fall_a: assert property ($changed(o_link_miso) |-> i_link_cs_n || $past(i_link_cs_n, 3)
    || !($past(i_link_clk, 2) && $past(i_link_clk, 3) && $past(i_link_clk, 4)))
    else $error("answer bit moved on a rising link clock");
  cover property (o_cmd_ack);
  cover property (o_cmd_nack);
  cover property (fell_w);
endmodule : psc_cmd_monitor

bind psc_cmd_fsm psc_cmd_monitor #(.FASTEST_CONVERSION_SETTING_CYC(FASTEST_CONVERSION_SETTING_CYC)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_link_cs_n(i_link_cs_n),
  .o_link_miso(o_link_miso), .o_conversion_done_n(o_conversion_done_n), .o_cmd_ack(o_cmd_ack),
  .o_cmd_nack(o_cmd_nack)
);

// ---- tb/psc_host_model.sv ----
// host side of the serial link: one command frame per go pulse
`timescale 1ns/100ps
module psc_host_model (
  // bench handshake
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [7:0] i_cmd,
  // link pins
  input wire logic i_miso,
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_mosi,
  // finished frame
  output logic o_valid,
  output logic [31:0] o_answer
);
  logic [7:0] cmd_q;
  logic [31:0] ans;
  int frame = 0;
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_valid = 1'b0;
    o_answer = 32'h0;
  end
  // link clock only inside frames, phase drifting against the system clock
  always @(posedge i_sys_clk) begin
    if (i_go) begin
      cmd_q = i_cmd;
      frame++;
      #(1 + frame % 17) o_cs_n = 1'b0;
      for (int i = 0; i < 40; i++) begin
        o_mosi = (i < 8) ? cmd_q[7 - i] : ~o_mosi; // released line toggles
        #80 o_link_clk = 1'b1;
        ans = {ans[30:0], i_miso};
        #80 o_link_clk = 1'b0;
      end
      #80 o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      @(posedge i_sys_clk);
      o_valid <= 1'b1;
      o_answer <= ans;
      @(posedge i_sys_clk);
      o_valid <= 1'b0;
    end
  end
endmodule : psc_host_model

// ---- tb/tb_psc_cmd_fsm.sv ----
// self-checking bench for the command block
`timescale 1ns/100ps
module tb_psc_cmd_fsm;
  import psc_pkg::*;
  localparam int unsigned MC[4] = '{20, 40, 80, 160};
  localparam int unsigned EXTRA = 30;
  localparam logic [31:0] ACK_W = {ANS_ACK, 24'h0};
  localparam logic [31:0] NACK_W = {ANS_NACK, 24'h0};
  localparam logic [31:0] HDR = 32'hff000000;
  localparam logic [31:0] FULL = 32'hffffffff;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] cmd = 8'h0;
  logic [DATA_W-1:0] sample = 24'h0;
  logic [DATA_W-1:0] offset = 24'h0;
  logic link_clk, cs_n, mosi, miso, done_n, ack, nack, valid, prev_done;
  logic [31:0] answer, e, m;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int since_ack = 0;
  int fall_gap = 0;
  int nacks_exp = 0;
  int nacks_seen = 0;
  int seed = 32'hab0f;

  always #10 i_sys_clk = ~i_sys_clk;

  psc_cmd_fsm #(.FASTEST_CONVERSION_SETTING_CYC(MC[0]), .SECOND_CONVERSION_SETTING_CYC(MC[1]), .THIRD_CONVERSION_SETTING_CYC(MC[2]), .SLOWEST_CONVERSION_SETTING_CYC(MC[3]), .EXTRA_CYC(EXTRA)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_link_clk(link_clk), .i_link_cs_n(cs_n),
    .i_link_mosi(mosi), .o_link_miso(miso), .i_proto_sel(1'b1),
    .i_bridge_sample(sample), .i_temp_offset(offset), .o_conversion_done_n(done_n),
    .o_cmd_ack(ack), .o_cmd_nack(nack)
  );
  psc_host_model host (
    .i_sys_clk(i_sys_clk), .i_go(go), .i_cmd(cmd), .i_miso(miso), .o_link_clk(link_clk),
    .o_cs_n(cs_n), .o_mosi(mosi), .o_valid(valid), .o_answer(answer)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // note the expected answer, then run one frame
  task automatic send(input logic [7:0] c, input logic [31:0] ex, input logic [31:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    if (ex[31:24] == ANS_NACK) nacks_exp++;
    cmd <= c;
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    for (int n = 0; n < 600 && valid !== 1'b1; n++) @(posedge i_sys_clk);
    repeat (4) @(posedge i_sys_clk);
  endtask : send

  function automatic logic [31:0] stat(input logic [1:0] st, input logic [1:0] md, input logic [1:0] ct);
    return {ANS_ACK, 16'h0, 1'b1, 1'b0, st, md, ct};
  endfunction : stat

  // oldest note against each finished frame
  always @(posedge i_sys_clk) begin
    if (valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 32'h0;
      m = msk_q.size() ? msk_q.pop_front() : FULL;
      check("answer", e & m, answer & m);
    end
  end

  // completion timing from the last accepted command, and the hang limit;
  // sampled mid-cycle so the combinational pulses are settled, not racing the edge
  always @(negedge i_sys_clk) begin
    cycles++;
    since_ack = (ack === 1'b1) ? 0 : since_ack + 1;
    if (nack === 1'b1) nacks_seen++;
    if (prev_done === 1'b1 && done_n === 1'b0) fall_gap = since_ack;
    prev_done = done_n;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (600) @(posedge i_sys_clk);
    send(CMD_STATUS, stat(2'h0, 2'h0, 2'h0), FULL);
    send(CMD_RESULT, NACK_W, HDR);
    send({CMD_FILTER_HI, 2'h1}, NACK_W, HDR);
    send(CMD_IDLE, ACK_W, HDR);
    repeat (600) @(posedge i_sys_clk);
    send({CMD_FILTER_HI, 2'h2}, ACK_W, HDR);
    send(CMD_STATUS, stat(2'h2, 2'h0, 2'h2), FULL);
    send({CMD_FILTER_HI, 2'h0}, ACK_W, HDR);
    send(CMD_RESULT, ACK_W, FULL);
    send(CMD_IDLE, ACK_W, HDR);
    send(CMD_STATUS, stat(2'h2, 2'h0, 2'h0), FULL);
    // every setting from idle; leave active by reset, never by idle
    for (int k = 0; k < 4; k++) begin
      int ex;
      // the first start after power-on is a temperature pass and runs long
      ex = MC[k] + ((k == 0) ? EXTRA : 0) + 1;
      fall_gap = -1;
      send({CMD_ACTIVE_HI, k[1:0]}, ACK_W, HDR);
      check("conv cycles", ex, (fall_gap >= ex - 1 && fall_gap <= ex + 1) ? ex : fall_gap);
      send(CMD_STATUS, stat(2'h3, k[1:0], 2'h0), FULL);
      send({CMD_ACTIVE_HI, k[1:0]}, NACK_W, HDR);
      send(CMD_RESET, ACK_W, HDR);
      repeat (600) @(posedge i_sys_clk);
      send(CMD_IDLE, ACK_W, HDR);
      repeat (600) @(posedge i_sys_clk);
    end
    send(CMD_RESET, ACK_W, HDR);
    send(CMD_STATUS, stat(2'h1, 2'h0, 2'h0), FULL);
    send(CMD_STATUS, stat(2'h0, 2'h0, 2'h0), FULL);
    sample <= 24'($random(seed));
    offset <= 24'($random(seed));
    send({CMD_ACTIVE_HI, 2'h0}, ACK_W, HDR);
    repeat (7000) @(posedge i_sys_clk);
    check("completion", 32'h0, 32'(done_n));
    send(CMD_RESULT, {ANS_ACK, sample - offset}, FULL);
    send(CMD_STATUS, stat(2'h3, 2'h0, 2'h0), FULL);
    check("nack pulses", nacks_exp, nacks_seen);
    print_verdict();
  end
endmodule : tb_psc_cmd_fsm
